// file: logic/bridge_cmdstat_pkg.sv
package bridge_cmdstat_pkg;

	localparam logic [7:0] CMD_OFFSET = 8'h04;
	localparam logic [7:0] STAT_OFFSET = 8'h06;
	localparam logic [15:0] CMD_RESET = 16'h0000;
	localparam logic [15:0] STAT_RESET = 16'h0290;
	// Command bits that software can change: 9, 8, 6, 5, 2, 1, 0.
	localparam logic [15:0] CMD_WMASK = 16'h0367;
	// Status bits cleared by writing one: 15 to 11 and 8.
	localparam logic [15:0] STAT_W1C_MASK = 16'hf900;

	localparam int CMD_IO_EN = 0;
	localparam int CMD_MEM_EN = 1;
	localparam int CMD_MASTER_EN = 2;
	localparam int CMD_PALETTE_EN = 5;
	localparam int CMD_PERR_RESP = 6;
	localparam int CMD_SERR_EN = 8;
	localparam int CMD_FBB_EN = 9;

	localparam int STAT_66MHZ = 5;
	localparam int STAT_DATA_PERR = 8;
	localparam int STAT_SIG_TABORT = 11;
	localparam int STAT_RCV_TABORT = 12;
	localparam int STAT_RCV_MABORT = 13;
	localparam int STAT_SIG_SERR = 14;
	localparam int STAT_DET_PERR = 15;

	// Fixed fields: select timing 01b at 10:9, fast back-to-back capable, capabilities list.
	localparam logic [15:0] STAT_FIXED = 16'h0290;

	localparam logic [9:0] PAL_ADDR_MASK = 10'h3c6;
	localparam logic [9:0] PAL_ADDR_READ = 10'h3c8;
	localparam logic [9:0] PAL_ADDR_DATA = 10'h3c9;

	// Configuration access from the primary target logic, one per clock.
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [3:0] be;
		logic [31:0] wdata;
	} cfg_req_s;

	// Error events from the primary interface, each a one-cycle pulse.
	typedef struct packed {
		logic det_perr;
		logic serr;
		logic rcv_mabort;
		logic rcv_tabort;
		logic sig_tabort;
		logic perr_line;
		logic was_master;
	} err_evt_s;

	typedef struct packed {
		logic io_fwd_en;
		logic mem_fwd_en;
		logic master_en;
		logic sec_claim_en;
		logic perr_resp_en;
		logic serr_drive_en;
		logic fbb_en;
	} ctrl_s;

endpackage

// file: logic/palette_snoop_match.sv
`timescale 1ns/1ps
`default_nettype none
module palette_snoop_match
	import bridge_cmdstat_pkg::*;
(
	input wire logic [31:0] io_addr_i,
	input wire logic io_write_i,
	input wire logic snoop_en_i,
	output logic hit_o
);
	// Only the low ten lines are decoded so that every ISA alias matches.
	wire logic [9:0] low_addr = io_addr_i[9:0]; // RQ8
	wire logic addr_hit = (low_addr == PAL_ADDR_MASK) || (low_addr == PAL_ADDR_READ)
		|| (low_addr == PAL_ADDR_DATA);
	assign hit_o = snoop_en_i && io_write_i && addr_hit; // RQ7
endmodule
`default_nettype wire

// file: logic/bridge_cmdstat_regs.sv
// Notes on behaviour
// RQ1 - Command register sits at offset 04h and clears fully on reset.
// RQ2 - Command bits 15 to 10 read zero and ignore writes.
// RQ3 - Bit 9 is a writable fast back-to-back enable, zero after reset.
// RQ4 - System error output is driven only while command bit 8 is one.
// RQ5 - No address/data stepping; bit 7 reads zero, ignores writes.
// RQ6 - Parity error response only while bit 6 is set; clear after reset.
// RQ7 - With snoop enabled, palette I/O writes pass to the secondary bus.
// RQ8 - Palette decode compares address lines 9 to 0 only.
// RQ9 - Memory write and invalidate enable, bit 4, reads zero.
// RQ10 - Special cycles never claimed; bit 3 reads zero.
// RQ11 - Primary cycles initiated only while bus master enable bit 2 is set.
// RQ12 - Without bus master enable, no secondary memory or I/O claims.
// RQ13 - Memory forwarding downstream only while memory space enable is set.
// RQ14 - I/O forwarding downstream only while I/O space enable is set.
// RQ15 - Writing one to a status flag clears it.
// RQ16 - Writing zero to a status flag leaves it unchanged.
// RQ17 - Status register at offset 06h, reset value 0290h.
// RQ18 - Status bit 14 sets on signalled system error when enabled.
// RQ19 - Status bit 8 sets on data parity error as master with response on.
// RQ20 - Status bits 10 to 9 read fixed 01b.
// RQ21 - Status bit 5 follows the 66 MHz strap.
`timescale 1ns/1ps
`default_nettype none
module bridge_cmdstat_regs
	import bridge_cmdstat_pkg::*;
(
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire cfg_req_s cfg_i,
	input wire err_evt_s evt_i,
	input wire logic primary_66mhz_strap_i,
	input wire logic [31:0] io_addr_i,
	input wire logic io_write_i,
	output logic [31:0] cfg_rdata_o,
	output logic cfg_ack_o,
	output ctrl_s ctrl_o,
	output logic serr_o,
	output logic serr_oe_o,
	output logic palette_fwd_o
);
	logic [15:0] cmd_q;
	logic [15:0] cmd_d;
	logic [15:0] flags_q;
	logic [15:0] flags_d;
	logic strap_meta_q;
	logic strap_sync_q;
	logic [31:0] rdata_q;
	logic ack_q;
	ctrl_s ctrl_q;
	logic serr_q;
	logic serr_oe_q;
	logic pal_q;
	logic pal_hit;

	// Merge one 16-bit half of a dword write under its byte enables.
	function automatic logic [15:0] lane_merge(input logic [15:0] old_v,
		input logic [15:0] new_v, input logic [1:0] be);
		lane_merge = {be[1] ? new_v[15:8] : old_v[15:8], be[0] ? new_v[7:0] : old_v[7:0]};
	endfunction

	// Both registers share the dword at 04h; the status half is the upper word.
	wire logic dword_hit = (cfg_i.addr[7:2] == CMD_OFFSET[7:2]);
	wire logic cmd_wr = cfg_i.wr && dword_hit; // RQ1
	wire logic stat_wr = cfg_i.wr && dword_hit && (STAT_OFFSET[1] == 1'b1); // RQ17
	wire logic [15:0] cmd_wr_val = lane_merge(cmd_q, cfg_i.wdata[15:0], cfg_i.be[1:0]);
	wire logic [15:0] cmd_bits_written = {{8{cfg_i.be[1]}}, {8{cfg_i.be[0]}}};
	wire logic [15:0] w1c = cfg_i.wdata[31:16] & {{8{cfg_i.be[3]}}, {8{cfg_i.be[2]}}}
		& STAT_W1C_MASK & {16{stat_wr}}; // RQ15 RQ16

	// Fixed-zero command bits never store anything.
	assign cmd_d = cmd_wr ? ((cmd_wr_val & CMD_WMASK) | (cmd_q & ~CMD_WMASK & ~cmd_bits_written))
		& CMD_WMASK : cmd_q; // RQ2 RQ5 RQ9 RQ10

	// Event sets take priority over a clear in the same cycle.
	wire logic [15:0] set_v = {
		evt_i.det_perr,
		evt_i.serr & cmd_q[CMD_SERR_EN], // RQ18
		evt_i.rcv_mabort,
		evt_i.rcv_tabort,
		evt_i.sig_tabort,
		2'b00,
		evt_i.perr_line & evt_i.was_master & cmd_q[CMD_PERR_RESP], // RQ19
		8'h00};
	assign flags_d = ((flags_q & ~w1c) | set_v) & STAT_W1C_MASK;

	// The strap sits outside the clock domain and is synchronised first.
	wire logic [15:0] stat_view = flags_q | STAT_FIXED
		| (16'(strap_sync_q) << STAT_66MHZ); // RQ20 RQ21
	wire logic [31:0] rd_val = dword_hit ? {stat_view, cmd_q} : 32'h0000_0000;

	palette_snoop_match u_pal (
		.io_addr_i(io_addr_i),
		.io_write_i(io_write_i),
		.snoop_en_i(cmd_q[CMD_PALETTE_EN]),
		.hit_o(pal_hit)
	);

	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			cmd_q <= CMD_RESET; // RQ1 RQ3 RQ6
			flags_q <= STAT_RESET & STAT_W1C_MASK; // RQ17
			strap_meta_q <= 1'b0;
			strap_sync_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			ack_q <= 1'b0;
			ctrl_q <= '0;
			serr_q <= 1'b0;
			serr_oe_q <= 1'b0;
			pal_q <= 1'b0;
		end
		else
		begin
			cmd_q <= cmd_d;
			flags_q <= flags_d;
			strap_meta_q <= primary_66mhz_strap_i;
			strap_sync_q <= strap_meta_q;
			rdata_q <= cfg_i.rd ? rd_val : rdata_q;
			ack_q <= cfg_i.rd || cfg_i.wr;
			ctrl_q.io_fwd_en <= cmd_d[CMD_IO_EN]; // RQ14
			ctrl_q.mem_fwd_en <= cmd_d[CMD_MEM_EN]; // RQ13
			ctrl_q.master_en <= cmd_d[CMD_MASTER_EN]; // RQ11
			ctrl_q.sec_claim_en <= cmd_d[CMD_MASTER_EN]; // RQ12
			ctrl_q.perr_resp_en <= cmd_d[CMD_PERR_RESP]; // RQ6
			ctrl_q.serr_drive_en <= cmd_d[CMD_SERR_EN]; // RQ4
			ctrl_q.fbb_en <= cmd_d[CMD_FBB_EN]; // RQ3
			serr_q <= 1'b0;
			serr_oe_q <= evt_i.serr && cmd_q[CMD_SERR_EN]; // RQ4
			pal_q <= pal_hit; // RQ7
		end
	end

	assign cfg_rdata_o = rdata_q;
	assign cfg_ack_o = ack_q;
	assign ctrl_o = ctrl_q;
	assign serr_o = serr_q;
	assign serr_oe_o = serr_oe_q;
	assign palette_fwd_o = pal_q;

	property p_serr_gated;
		@(posedge clk_i) disable iff (!rstn_i) !cmd_q[CMD_SERR_EN] |=> !serr_oe_o;
	endproperty
	a_serr_gated: assert property (p_serr_gated) else $error("serr driven while disabled"); // RQ4

	property p_cmd_reserved;
		@(posedge clk_i) disable iff (!rstn_i) ##1 (cmd_q & ~CMD_WMASK) == 16'h0000;
	endproperty
	a_cmd_reserved: assert property (p_cmd_reserved) else $error("fixed command bit set"); // RQ2

	property p_w1c_clear;
		@(posedge clk_i) disable iff (!rstn_i)
			(stat_wr && cfg_i.be[3] && cfg_i.wdata[31] && !evt_i.det_perr) |=> !flags_q[STAT_DET_PERR];
	endproperty
	a_w1c_clear: assert property (p_w1c_clear) else $error("flag not cleared"); // RQ15

	property p_w0_keep;
		@(posedge clk_i) disable iff (!rstn_i)
			(flags_q[STAT_RCV_MABORT] && !(stat_wr && cfg_i.be[3] && cfg_i.wdata[29]))
			|=> flags_q[STAT_RCV_MABORT];
	endproperty
	a_w0_keep: assert property (p_w0_keep) else $error("flag lost without write one"); // RQ16

	property p_sig_serr;
		@(posedge clk_i) disable iff (!rstn_i)
			(evt_i.serr && cmd_q[CMD_SERR_EN]) |=> flags_q[STAT_SIG_SERR];
	endproperty
	a_sig_serr: assert property (p_sig_serr) else $error("system error flag not set"); // RQ18

	property p_data_perr;
		@(posedge clk_i) disable iff (!rstn_i)
			(!flags_q[STAT_DATA_PERR] && evt_i.perr_line && !cmd_q[CMD_PERR_RESP])
			|=> !flags_q[STAT_DATA_PERR];
	endproperty
	a_data_perr: assert property (p_data_perr) else $error("parity flag set without response"); // RQ19

	property p_timing_field;
		@(posedge clk_i) disable iff (!rstn_i) stat_view[10:9] == 2'b01 && stat_view[4];
	endproperty
	a_timing_field: assert property (p_timing_field) else $error("fixed status field wrong"); // RQ20

	property p_master_ctrl;
		@(posedge clk_i) disable iff (!rstn_i)
			##1 ctrl_o.master_en == cmd_q[CMD_MASTER_EN] && ctrl_o.sec_claim_en == ctrl_o.master_en;
	endproperty
	a_master_ctrl: assert property (p_master_ctrl) else $error("master enable mismatch"); // RQ11

	property p_palette;
		@(posedge clk_i) disable iff (!rstn_i)
			(io_write_i && cmd_q[CMD_PALETTE_EN] && io_addr_i[9:0] == PAL_ADDR_DATA) |=> palette_fwd_o;
	endproperty
	a_palette: assert property (p_palette) else $error("palette write not passed"); // RQ7

	// Steps that several properties below start from.
	sequence s_cmd_write;
		cfg_i.wr && dword_hit;
	endsequence

	sequence s_dword_read;
		cfg_i.rd && dword_hit;
	endsequence

	sequence s_serr_signalled;
		evt_i.serr && cmd_q[CMD_SERR_EN];
	endsequence

	property p_cfg_ack;
		@(posedge clk_i) disable iff (!rstn_i)
			(cfg_i.wr || cfg_i.rd) |=> cfg_ack_o;
	endproperty
	a_cfg_ack: assert property (p_cfg_ack) else $error("request not acknowledged"); // RQ1

	property p_read_cmd;
		@(posedge clk_i) disable iff (!rstn_i)
			s_dword_read |=> cfg_rdata_o[15:0] == $past(cmd_q);
	endproperty
	a_read_cmd: assert property (p_read_cmd) else $error("command readback wrong"); // RQ1

	property p_read_stat;
		@(posedge clk_i) disable iff (!rstn_i)
			s_dword_read |=> cfg_rdata_o[31:16] == $past(stat_view);
	endproperty
	a_read_stat: assert property (p_read_stat) else $error("status readback wrong"); // RQ17

	property p_read_other;
		@(posedge clk_i) disable iff (!rstn_i)
			(cfg_i.rd && !dword_hit) |=> cfg_rdata_o == 32'h0000_0000;
	endproperty
	a_read_other: assert property (p_read_other) else $error("unmapped read not zero"); // RQ1

	// Read data is a register, so it must stand until the next read replaces it.
	property p_rdata_hold;
		@(posedge clk_i) disable iff (!rstn_i)
			!cfg_i.rd |=> $stable(cfg_rdata_o);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved"); // RQ1

	property p_cmd_hold;
		@(posedge clk_i) disable iff (!rstn_i)
			!(cfg_i.wr && dword_hit) |=> $stable(cmd_q);
	endproperty
	a_cmd_hold: assert property (p_cmd_hold) else $error("command changed without write"); // RQ1

	property p_cmd_write;
		@(posedge clk_i) disable iff (!rstn_i)
			(s_cmd_write ##0 (cfg_i.be[1:0] == 2'b11))
			|=> cmd_q == (16'($past(cfg_i.wdata)) & CMD_WMASK);
	endproperty
	a_cmd_write: assert property (p_cmd_write) else $error("command write not stored"); // RQ3

	property p_io_fwd;
		@(posedge clk_i) disable iff (!rstn_i)
			##1 ctrl_o.io_fwd_en == cmd_q[CMD_IO_EN];
	endproperty
	a_io_fwd: assert property (p_io_fwd) else $error("io forward enable wrong"); // RQ14

	property p_mem_fwd;
		@(posedge clk_i) disable iff (!rstn_i)
			##1 ctrl_o.mem_fwd_en == cmd_q[CMD_MEM_EN];
	endproperty
	a_mem_fwd: assert property (p_mem_fwd) else $error("memory forward enable wrong"); // RQ13

	property primary_parity_error_line_resp;
		@(posedge clk_i) disable iff (!rstn_i)
			##1 ctrl_o.perr_resp_en == cmd_q[CMD_PERR_RESP];
	endproperty
	a_perr_resp: assert property (primary_parity_error_line_resp) else $error("parity response enable wrong"); // RQ6

	property p_serr_enable;
		@(posedge clk_i) disable iff (!rstn_i)
			##1 ctrl_o.serr_drive_en == cmd_q[CMD_SERR_EN];
	endproperty
	a_serr_enable: assert property (p_serr_enable) else $error("serr enable wrong"); // RQ4

	property p_serr_pulse;
		@(posedge clk_i) disable iff (!rstn_i)
			s_serr_signalled |=> serr_oe_o && !serr_o;
	endproperty
	a_serr_pulse: assert property (p_serr_pulse) else $error("serr not driven"); // RQ4

	property p_serr_quiet;
		@(posedge clk_i) disable iff (!rstn_i)
			!evt_i.serr |=> !serr_oe_o;
	endproperty
	a_serr_quiet: assert property (p_serr_quiet) else $error("serr driven without event"); // RQ4

	property p_serr_flag_off;
		@(posedge clk_i) disable iff (!rstn_i)
			(evt_i.serr && !cmd_q[CMD_SERR_EN] && !flags_q[STAT_SIG_SERR]) |=> !flags_q[STAT_SIG_SERR];
	endproperty
	a_serr_flag_off: assert property (p_serr_flag_off) else $error("serr flag set while off"); // RQ18

	property primary_parity_error_line_set;
		@(posedge clk_i) disable iff (!rstn_i)
			(evt_i.perr_line && evt_i.was_master && cmd_q[CMD_PERR_RESP]) |=> flags_q[STAT_DATA_PERR];
	endproperty
	a_perr_set: assert property (primary_parity_error_line_set) else $error("parity flag not set"); // RQ19

	property primary_parity_error_line_master;
		@(posedge clk_i) disable iff (!rstn_i)
			(evt_i.perr_line && !evt_i.was_master && !flags_q[STAT_DATA_PERR])
			|=> !flags_q[STAT_DATA_PERR];
	endproperty
	a_perr_master: assert property (primary_parity_error_line_master) else $error("parity flag set as target"); // RQ19

	// The strap crosses two flops, so it is held against its value two edges back.
	property p_strap;
		@(posedge clk_i) disable iff (!rstn_i)
			##2 stat_view[STAT_66MHZ] == $past(primary_66mhz_strap_i, 2);
	endproperty
	a_strap: assert property (p_strap) else $error("66 MHz status bit wrong"); // RQ21

	property p_palette_miss;
		@(posedge clk_i) disable iff (!rstn_i)
			(io_addr_i[9:0] != PAL_ADDR_MASK && io_addr_i[9:0] != PAL_ADDR_READ
				&& io_addr_i[9:0] != PAL_ADDR_DATA) |=> !palette_fwd_o;
	endproperty
	a_palette_miss: assert property (p_palette_miss) else $error("other write passed"); // RQ8
endmodule
`default_nettype wire

// file: verification/host_evt_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_evt_model
	import bridge_cmdstat_pkg::*;
(
	input wire logic fire_i,
	input wire logic master_i,
	output err_evt_s evt_o
);
	// All error sources fire together in one pulse; flags 14 and 8 still need their enables, and flag 8 also needs master_i.
	assign evt_o = fire_i ? {6'h3f, master_i} : '0;
endmodule
`default_nettype wire

// file: verification/bridge_primary_command_status_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
module bridge_primary_command_status_regs_test
	import bridge_cmdstat_pkg::*;
;
	logic clk_i = 0, rstn_i = 0, strap = 0, fire = 0, mst = 0, io_wr = 0;
	logic ack, serr, serr_oe, pal;
	logic [31:0] io_addr = '0, rdata, d;
	logic [32:0] exp_q[$], nt;
	logic [15:0] st;
	logic [9:0] pa[4] = '{10'h3c6, 10'h3c8, 10'h3c9, 10'h3c7};
	cfg_req_s cfg = '0;
	err_evt_s evt;
	ctrl_s ctrl;
	int miscompares = 0, tests_run = 0, cyc = 0;

	initial forever #50 clk_i = ~clk_i;

	host_evt_model u_host_evt_model(.fire_i(fire), .master_i(mst), .evt_o(evt));
	bridge_cmdstat_regs u_bridge_cmdstat_regs(.clk_i(clk_i), .rstn_i(rstn_i), .cfg_i(cfg),
		.evt_i(evt), .primary_66mhz_strap_i(strap), .io_addr_i(io_addr), .io_write_i(io_wr),
		.cfg_rdata_o(rdata), .cfg_ack_o(ack), .ctrl_o(ctrl), .serr_o(serr),
		.serr_oe_o(serr_oe), .palette_fwd_o(pal));

	task automatic chk(input logic [31:0] s, input logic [31:0] e, input string n);
		tests_run++;
		if (s !== e)
		begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// One request per call; the next call starts only after the answer cycle.
	task automatic op(input logic w, input logic r, input logic [3:0] be, input logic [31:0] wd,
		input logic [7:0] a, input logic [31:0] e);
		cfg = '{w, r, a, be, wd};
		exp_q.push_back({r, e});
		@(negedge clk_i);
		cfg = '0;
		@(negedge clk_i);
	endtask

	always @(negedge clk_i)
	begin
		cyc++;
		if (ack === 1'b1 && exp_q.size() > 0)
		begin
			nt = exp_q.pop_front();
			if (nt[32])
				chk(rdata, nt[31:0], "rdata");
		end
		if (cyc > 3000)
		begin
			miscompares++;
			wrap_up();
		end
	end

	initial
	begin
		void'($urandom(83));
		strap = 1'($urandom);
		repeat (2) @(negedge clk_i);
		rstn_i = 1;
		repeat (3) @(negedge clk_i);
		st = STAT_RESET | (16'(strap) << STAT_66MHZ);
		op(0, 1, 4'hf, 0, CMD_OFFSET, {st, CMD_RESET});
		for (int i = 0; i < 8; i++)
		begin
			d = $urandom;
			op(1, 0, 4'h3, d, CMD_OFFSET, 0);
			chk({25'h0, ctrl}, {25'h0, d[0], d[1], d[2], d[2], d[6], d[8], d[9]}, "ctrl");
			op(0, 1, 4'hf, 0, CMD_OFFSET, {st, d[15:0] & CMD_WMASK});
		end
		for (int j = 1; j >= 0; j--)
		begin
			op(1, 0, 4'h3, j ? 32'h0367 : 32'h0347, CMD_OFFSET, 0);
			for (int i = 0; i < 4; i++)
			begin
				io_addr = ($urandom & 32'hfffffc00) | {22'h0, pa[i]};
				io_wr = 1;
				@(negedge clk_i);
				chk({31'h0, pal}, j == 1 && i < 3, "palette");
				io_wr = 0;
				@(negedge clk_i);
			end
		end
		// The first pass must see every enable off, so the command is cleared here.
		op(1, 0, 4'h3, 0, CMD_OFFSET, 0);
		for (int j = 0; j < 3; j++)
		begin
			mst = (j < 2);
			fire = 1;
			@(negedge clk_i);
			fire = 0;
			chk({30'h0, serr_oe, serr}, j ? 2 : 0, "serr");
			@(negedge clk_i);
			st = STAT_RESET | (16'(strap) << STAT_66MHZ)
				| (j == 0 ? 16'hb800 : j == 1 ? 16'hf900 : 16'hf800);
			op(0, 1, 4'hf, 0, CMD_OFFSET, {st, j ? 16'h0347 : 16'h0});
			op(1, 0, 4'hc, 0, CMD_OFFSET, 0);
			op(0, 1, 4'hf, 0, CMD_OFFSET, {st, j ? 16'h0347 : 16'h0});
			op(1, 0, 4'hc, 32'h80000000, CMD_OFFSET, 0);
			st[15] = 0;
			op(0, 1, 4'hf, 0, CMD_OFFSET, {st, j ? 16'h0347 : 16'h0});
			op(1, 0, 4'hc, 32'hffff0000, CMD_OFFSET, 0);
			op(1, 0, 4'h3, 32'h0347, CMD_OFFSET, 0);
		end
		op(0, 1, 4'hf, 0, 8'h08, 0);
		repeat (2) @(negedge clk_i);
		wrap_up();
	end
endmodule
`default_nettype wire
